/* hw/tx_mode_control.sv */
// Transmit mode and interrupt-pin control registers with decoded outputs
`default_nettype none
// What this block does
// - With pin enable set, interrupt pin is driven low while interrupt bit is set.
// - With pin enable clear, interrupt pin floats whatever the interrupt status.
// - Six mask bits choose which status conditions may raise the interrupt bit.
// - Transmit mode clears on general reset and stays clear while internal reset set.
// - Mode field bits 15-12 select modem standard or tones.
// - Odd paired modem codes 6-D transmit high band, even codes low band; in codes 2-5 odd selects fast rate.
// - Level field sets gain in 1.5 dB steps, 111 loudest, 000 quietest.
// - Tones mode twist code sets upper group boost from +1.0 to +4.5 dB.
// - A new twist never takes effect partway through a tone.
// - In phase modes, scrambler field enables scrambler and 64-ones detector.
// - Format field selects synchronous or start-stop with none, even or odd parity.
// - Start-stop uses five plus bits 2-1 data bits, one plus bit 0 stop bits.
// - Synchronous source: 1XX buffer bytes, 011 ones, 010 zeros.
// - Source 00X sends dibits 00,11 at 1200 phase mode, else alternating bits.
module tx_mode_control
	import tx_mode_pkg::*;
(
	input  wire logic                 i_clk_sys,
	input  wire logic                 i_sys_rst,
	input  wire logic                 i_wr_stb,
	input  wire logic [7:0]           i_wr_addr,
	input  wire logic [15:0]          i_wr_data,
	input  wire logic [IRQ_SRC_W-1:0] i_status_flags,
	input  wire logic                 i_tone_active,
	output var  tx_cfg_s              o_tx_cfg,
	output var  logic [3:0]           o_twist_half_db,
	output var  logic                 o_int_reset,
	output var  logic                 o_irq_bit,
	output var  logic                 o_irq_n_out,
	output var  logic                 o_irq_n_oe
);

	////////////////////////////////////////////////////////////////////////
	// Register writes

	logic [15:0] tx_mode_ff;
	logic [15:0] nxt_tx_mode;
	logic [15:0] gen_ctrl_ff;
	logic [15:0] nxt_gen_ctrl;
	logic        is_gen_reset;
	logic        is_gen_wr;
	logic        is_tx_wr;

	assign is_gen_reset = i_wr_stb && (i_wr_addr == ADDR_GEN_RESET);
	assign is_gen_wr    = i_wr_stb && (i_wr_addr == ADDR_GEN_CTRL);
	assign is_tx_wr     = i_wr_stb && (i_wr_addr == ADDR_TX_MODE);

	always_comb begin
		nxt_gen_ctrl = gen_ctrl_ff;
		nxt_tx_mode  = tx_mode_ff;
		if (is_gen_reset)
			nxt_gen_ctrl = GEN_CTRL_RST;
		else if (is_gen_wr)
			nxt_gen_ctrl = i_wr_data;
		// Strobe only comes with a complete word, so fields move as one
		if (is_tx_wr)
			nxt_tx_mode = i_wr_data;
		// Internal reset wins over a write in the same cycle
		if (is_gen_reset || nxt_gen_ctrl[GC_INT_RST_BIT])
			nxt_tx_mode = TX_MODE_RST;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			gen_ctrl_ff <= GEN_CTRL_RST;
			tx_mode_ff  <= TX_MODE_RST;
		end else begin
			gen_ctrl_ff <= nxt_gen_ctrl;
			tx_mode_ff  <= nxt_tx_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decoded configuration

	tx_cfg_s    dec_cfg;
	logic [3:0] dec_twist;
	tx_cfg_s    cfg_ff;
	tx_cfg_s    nxt_cfg;
	logic [3:0] twist_ff;
	logic [3:0] nxt_twist;
	logic       rst_ff;
	logic       nxt_rst;

	tx_mode_decode u_decode (
		.i_mode_word (tx_mode_ff),
		.o_cfg       (dec_cfg),
		.o_twist     (dec_twist)
	);

	always_comb begin
		nxt_cfg   = dec_cfg;
		nxt_rst   = gen_ctrl_ff[GC_INT_RST_BIT];
		// Tone generator twist stays fixed until the tone ends
		nxt_twist = i_tone_active ? twist_ff : dec_twist;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cfg_ff   <= '0;
			twist_ff <= 4'h0;
			rst_ff   <= 1'b0;
		end else begin
			cfg_ff   <= nxt_cfg;
			twist_ff <= nxt_twist;
			rst_ff   <= nxt_rst;
		end
	end

	assign o_tx_cfg        = cfg_ff;
	assign o_twist_half_db = twist_ff;
	assign o_int_reset     = rst_ff;

	////////////////////////////////////////////////////////////////////////
	// Interrupt bit and open-drain pin

	logic irq_ff;
	logic nxt_irq;
	logic irq_oe_ff;
	logic nxt_irq_oe;

	always_comb begin
		nxt_irq    = |(i_status_flags & gen_ctrl_ff[GC_MASK_MSB:GC_MASK_LSB]);
		// Pin only ever pulls low; enable clear leaves it floating
		nxt_irq_oe = gen_ctrl_ff[GC_IRQ_EN_BIT] && nxt_irq;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			irq_ff    <= 1'b0;
			irq_oe_ff <= 1'b0;
		end else begin
			irq_ff    <= nxt_irq;
			irq_oe_ff <= nxt_irq_oe;
		end
	end

	assign o_irq_bit   = irq_ff;
	assign o_irq_n_out = 1'b0;
	assign o_irq_n_oe  = irq_oe_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_irq_pin_low: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(gen_ctrl_ff[GC_IRQ_EN_BIT] && |(i_status_flags & gen_ctrl_ff[GC_MASK_MSB:GC_MASK_LSB]))
		|=> (o_irq_n_oe && o_irq_bit))
		else $error("interrupt pin not pulled low");

	a_irq_pin_float: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!gen_ctrl_ff[GC_IRQ_EN_BIT] |=> !o_irq_n_oe)
		else $error("interrupt pin driven while disabled");

	a_irq_mask_gate: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		((i_status_flags & gen_ctrl_ff[GC_MASK_MSB:GC_MASK_LSB]) == '0) |=> !o_irq_bit)
		else $error("masked condition raised interrupt bit");

	a_txm_gen_reset: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		is_gen_reset |=> (tx_mode_ff == TX_MODE_RST) ##1 !o_tx_cfg.tx_on)
		else $error("general reset did not clear transmit mode");

	a_txm_hold_clear: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		gen_ctrl_ff[GC_INT_RST_BIT] |-> (tx_mode_ff == TX_MODE_RST))
		else $error("transmit mode not held clear in internal reset");

	a_cfg_band_sel: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(o_tx_cfg.tx_on && o_tx_cfg.std != STD_TONES && o_tx_cfg.std <= STD_BELL103)
		|-> (o_tx_cfg.high_band == $past(tx_mode_ff[TM_MODE_LSB])))
		else $error("band does not follow mode code parity");

	a_level_atten: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_tx_cfg.tx_on
		|-> (o_tx_cfg.atten_step == 3'(LEVEL_MAX_CODE - $past(tx_mode_ff[TM_LEVEL_MSB:TM_LEVEL_LSB]))))
		else $error("attenuation step does not match level code");

	a_twist_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_tone_active |=> $stable(o_twist_half_db))
		else $error("twist changed during a tone");

	a_write_atomic: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(!i_wr_stb && !gen_ctrl_ff[GC_INT_RST_BIT]) |=> $stable(tx_mode_ff))
		else $error("transmit mode changed without a write");

	a_tx_off_quiet: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!o_tx_cfg.tx_on |-> (o_tx_cfg == '0))
		else $error("disabled transmitter shows active fields");

	a_int_rst_out: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		gen_ctrl_ff[GC_INT_RST_BIT] |=> o_int_reset)
		else $error("internal reset not shown on output");

	// Idle tone generator takes the new twist one edge later
	a_twist_range: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(!i_tone_active && tx_mode_ff[TM_MODE_MSB:TM_MODE_LSB] == 4'h1)
		|=> (o_twist_half_db >= 4'h2 && o_twist_half_db <= 4'h9))
		else $error("twist outside its range in tones mode");

	a_scr_phase_only: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(o_tx_cfg.scramble_en || o_tx_cfg.ones_det_en) |-> (o_tx_cfg.dpsk && o_tx_cfg.scramble_en))
		else $error("scrambler active outside phase modes");

	a_scr_follow: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_tx_cfg.dpsk |-> (o_tx_cfg.scramble_en == $past(tx_mode_ff[TM_SCR_EN_BIT])))
		else $error("scrambler enable does not follow its bit");

	a_sync_framing: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		o_tx_cfg.sync_mode |-> (!o_tx_cfg.parity_en && o_tx_cfg.data_bits == 4'h0 && o_tx_cfg.sync_src != SRC_NONE))
		else $error("synchronous mode shows start-stop framing");

	a_frame_ranges: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(o_tx_cfg.tx_on && o_tx_cfg.std != STD_TONES && !o_tx_cfg.sync_mode)
		|-> (o_tx_cfg.data_bits >= DATA_BITS_BASE && o_tx_cfg.data_bits <= DATA_BITS_BASE + 4'h3
			&& o_tx_cfg.stop_bits >= STOP_BITS_BASE && o_tx_cfg.stop_bits <= STOP_BITS_BASE + 2'h1))
		else $error("start-stop character framing out of range");

	a_dibit_fast_psk: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(o_tx_cfg.sync_src == SRC_DIBITS) |-> (o_tx_cfg.std == STD_V22_1200))
		else $error("dibit pattern outside 1200 bps phase mode");

endmodule
`default_nettype wire

/* hw/tx_mode_decode.sv */
// Combinational decode of the transmit mode word into configuration fields
`default_nettype none
module tx_mode_decode
	import tx_mode_pkg::*;
(
	input  wire logic [15:0] i_mode_word,
	output var  tx_cfg_s     o_cfg,
	output var  logic [3:0]  o_twist
);

	logic [3:0] mode;
	logic [2:0] low;
	logic [1:0] fmt;

	assign mode = i_mode_word[TM_MODE_MSB:TM_MODE_LSB];
	assign low  = i_mode_word[TM_LOW_MSB:TM_LOW_LSB];
	assign fmt  = i_mode_word[TM_FMT_MSB:TM_FMT_LSB];

	always_comb begin
		o_cfg   = '0;
		o_twist = 4'h0;
		case (mode)
			4'hD, 4'hC: o_cfg.std = STD_V22_1200;
			4'hB, 4'hA: o_cfg.std = STD_V22_600;
			4'h9, 4'h8: o_cfg.std = STD_V21;
			4'h7, 4'h6: o_cfg.std = STD_BELL103;
			4'h5, 4'h4: o_cfg.std = STD_V23;
			4'h3, 4'h2: o_cfg.std = STD_BELL202;
			4'h1:       o_cfg.std = STD_TONES;
			default:    o_cfg.std = STD_OFF;
		endcase
		// Disabled transmitter leaves every other field at zero
		if (o_cfg.std != STD_OFF) begin
			o_cfg.tx_on      = 1'b1;
			o_cfg.dpsk       = (o_cfg.std == STD_V22_1200) || (o_cfg.std == STD_V22_600);
			o_cfg.atten_step = LEVEL_MAX_CODE - i_mode_word[TM_LEVEL_MSB:TM_LEVEL_LSB];
			if (o_cfg.std == STD_TONES) begin
				o_twist        = twist_half_db(i_mode_word[TM_TWIST_MSB:TM_TWIST_LSB]);
				o_cfg.tone_sel = i_mode_word[TM_TONE_MSB:0];
			end else begin
				o_cfg.high_band   = i_mode_word[TM_MODE_LSB] && o_cfg.std <= STD_BELL103;
				o_cfg.fast_rate   = i_mode_word[TM_MODE_LSB] && o_cfg.std >= STD_V23;
				// Scrambler bits only mean something in phase modes
				o_cfg.scramble_en = o_cfg.dpsk && i_mode_word[TM_SCR_EN_BIT];
				o_cfg.ones_det_en = o_cfg.scramble_en && i_mode_word[TM_ONES_DET_BIT];
				o_cfg.sync_mode   = (fmt == 2'h3);
				if (o_cfg.sync_mode) begin
					if (low[2])
						o_cfg.sync_src = SRC_BUFFER;
					else if (low[1])
						o_cfg.sync_src = low[0] ? SRC_ONES : SRC_ZEROS;
					else if (o_cfg.std == STD_V22_1200)
						o_cfg.sync_src = SRC_DIBITS;
					else
						o_cfg.sync_src = SRC_ALT;
				end else begin
					o_cfg.parity_en   = !fmt[1];
					o_cfg.parity_even = !fmt[1] && fmt[0];
					o_cfg.data_bits   = DATA_BITS_BASE + {2'h0, low[2:1]};
					o_cfg.stop_bits   = STOP_BITS_BASE + {1'b0, low[0]};
				end
			end
		end
	end

endmodule
`default_nettype wire

/* hw/tx_mode_pkg.sv */
// Register map, field layout and decoded transmit configuration types
`default_nettype none
package tx_mode_pkg;

	// Write addresses on the serial control bus
	localparam logic [7:0]  ADDR_GEN_RESET   = 8'h01;
	localparam logic [7:0]  ADDR_GEN_CTRL    = 8'hE0;
	localparam logic [7:0]  ADDR_TX_MODE     = 8'hE1;

	// Reset values
	localparam logic [15:0] TX_MODE_RST      = 16'h0000;
	localparam logic [15:0] GEN_CTRL_RST     = 16'h0000;

	// General control fields
	localparam int          GC_INT_RST_BIT   = 7;
	localparam int          GC_IRQ_EN_BIT    = 6;
	localparam int          GC_MASK_MSB      = 5;
	localparam int          GC_MASK_LSB      = 0;
	localparam int          IRQ_SRC_W        = 6;

	// Transmit mode fields
	localparam int          TM_MODE_MSB      = 15;
	localparam int          TM_MODE_LSB      = 12;
	localparam int          TM_LEVEL_MSB     = 11;
	localparam int          TM_LEVEL_LSB     = 9;
	localparam int          TM_TWIST_MSB     = 7;
	localparam int          TM_TWIST_LSB     = 5;
	localparam int          TM_SCR_EN_BIT    = 6;
	localparam int          TM_ONES_DET_BIT  = 5;
	localparam int          TM_FMT_MSB       = 4;
	localparam int          TM_FMT_LSB       = 3;
	localparam int          TM_LOW_MSB       = 2;
	localparam int          TM_LOW_LSB       = 0;
	localparam int          TM_TONE_MSB      = 4;

	localparam logic [2:0]  LEVEL_MAX_CODE   = 3'h7;
	localparam logic [3:0]  DATA_BITS_BASE   = 4'h5;
	localparam logic [1:0]  STOP_BITS_BASE   = 2'h1;

	typedef enum logic [2:0] {
		STD_OFF      = 3'h0,
		STD_V22_1200 = 3'h1,
		STD_V22_600  = 3'h2,
		STD_V21      = 3'h3,
		STD_BELL103  = 3'h4,
		STD_V23      = 3'h5,
		STD_BELL202  = 3'h6,
		STD_TONES    = 3'h7
	} tx_std_e;

	typedef enum logic [2:0] {
		SRC_NONE     = 3'h0,
		SRC_BUFFER   = 3'h1,
		SRC_ONES     = 3'h2,
		SRC_ZEROS    = 3'h3,
		SRC_DIBITS   = 3'h4,
		SRC_ALT      = 3'h5
	} sync_src_e;

	typedef struct packed {
		logic       tx_on;
		tx_std_e    std;
		logic       dpsk;
		logic       high_band;
		logic       fast_rate;
		logic [2:0] atten_step;
		logic       scramble_en;
		logic       ones_det_en;
		logic       sync_mode;
		logic       parity_en;
		logic       parity_even;
		logic [3:0] data_bits;
		logic [1:0] stop_bits;
		sync_src_e  sync_src;
		logic [4:0] tone_sel;
	} tx_cfg_s;

	// Upper-group boost in 0.5 dB units; code order is not monotonic
	function automatic logic [3:0] twist_half_db(input logic [2:0] code);
		case (code)
			3'h0:    twist_half_db = 4'h4;
			3'h1:    twist_half_db = 4'h2;
			3'h2:    twist_half_db = 4'h3;
			3'h3:    twist_half_db = 4'h5;
			default: twist_half_db = {1'b0, code} + 4'h2;
		endcase
	endfunction

endpackage
`default_nettype wire

/* testbench/host_model.sv */
// Host controller model issuing whole-word register writes
`default_nettype none
module host_model (
	input  wire logic        i_clk_sys,
	output var  logic        o_wr_stb,
	output var  logic [7:0]  o_wr_addr,
	output var  logic [15:0] o_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_wr_stb  = 1'b0;
		o_wr_addr = 8'h00;
		o_wr_data = 16'h0000;
	end
	// Idle bus shows inverted values so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		o_wr_stb  <= 1'b1;
		o_wr_addr <= a;
		o_wr_data <= d;
		@(posedge i_clk_sys);
		o_wr_stb  <= 1'b0;
		o_wr_addr <= ~a;
		o_wr_data <= ~d;
		@(posedge i_clk_sys);
		#1;
	endtask
endmodule
`default_nettype wire

/* testbench/tx_mode_control_tb.sv */
// Self-checking bench for the transmit mode control block
`default_nettype none
module tx_mode_control_tb
	import tx_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, stb, tone, int_rst, irq, irq_out, irq_oe;
	logic [7:0]  addr;
	logic [15:0] data;
	logic [5:0]  flags;
	logic [3:0]  twist;
	tx_cfg_s     cfg;
	int          err_total = 0;
	int          cmp_count = 0;
	localparam tx_std_e STD_TAB [16] = '{STD_OFF, STD_TONES, STD_BELL202, STD_BELL202, STD_V23, STD_V23,
		STD_BELL103, STD_BELL103, STD_V21, STD_V21, STD_V22_600, STD_V22_600, STD_V22_1200, STD_V22_1200,
		STD_OFF, STD_OFF};
	localparam logic [3:0] TW [8]    = '{4'h4, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
	localparam logic [3:0] MODES [3] = '{4'hC, 4'hB, 4'h8};

	host_model i_host_model (.i_clk_sys(clk), .o_wr_stb(stb), .o_wr_addr(addr), .o_wr_data(data));
	tx_mode_control i_tx_mode_control (.i_clk_sys(clk), .i_sys_rst(rst), .i_wr_stb(stb), .i_wr_addr(addr),
		.i_wr_data(data), .i_status_flags(flags), .i_tone_active(tone), .o_tx_cfg(cfg),
		.o_twist_half_db(twist), .o_int_reset(int_rst), .o_irq_bit(irq), .o_irq_n_out(irq_out),
		.o_irq_n_oe(irq_oe));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	task automatic fail(input string m);
		err_total++;
		$display("[ERR] %0t %s", $time, m);
	endtask
	task automatic chk_cfg(input tx_cfg_s e);
		cmp_count++;
		if (cfg !== e) fail($sformatf("cfg %h exp %h", cfg, e));
	endtask
	task automatic chk_bit(input logic g, input logic e, input string m);
		cmp_count++;
		if (g !== e) fail($sformatf("%s got %b", m, g));
	endtask
	task automatic chk_twist(input logic [3:0] e);
		cmp_count++;
		if (twist !== e) fail($sformatf("twist %h exp %h", twist, e));
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host_model.wr(a, d);
	endtask
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Expected decode worked out field by field
	function automatic tx_cfg_s exp_cfg(input logic [15:0] w);
		tx_cfg_s    c;
		logic [3:0] m;
		c = '0;
		m = w[15:12];
		c.std = STD_TAB[m];
		if (c.std == STD_OFF) return c;
		c.tx_on = 1'b1;
		c.atten_step = 3'h7 - w[11:9];
		if (m == 4'h1) begin
			c.tone_sel = w[4:0];
			return c;
		end
		c.dpsk = m >= 4'hA;
		c.high_band = m[0] && m >= 4'h6;
		c.fast_rate = m[0] && m <= 4'h5;
		c.scramble_en = c.dpsk & w[6];
		c.ones_det_en = c.scramble_en & w[5];
		c.sync_mode = &w[4:3];
		if (!c.sync_mode) begin
			c.parity_en = !w[4];
			c.parity_even = w[4:3] == 2'h1;
			c.data_bits = 4'h5 + w[2:1];
			c.stop_bits = 2'h1 + w[0];
		end else if (w[2]) c.sync_src = SRC_BUFFER;
		else if (w[1]) c.sync_src = w[0] ? SRC_ONES : SRC_ZEROS;
		else c.sync_src = m[3:1] == 3'h6 ? SRC_DIBITS : SRC_ALT;
		return c;
	endfunction
	////////////////////////////////////////////////////////////
	task automatic t_modes();
		logic [15:0] w;
		for (int i = 0; i < 16; i++) begin
			w = {i[3:0], i[2:0], 9'h013};
			wr(ADDR_TX_MODE, w);
			chk_cfg(exp_cfg(w));
		end
		$display("mode test done");
	endtask
	task automatic t_framing();
		logic [15:0] w;
		for (int i = 0; i < 384; i++) begin
			w = {MODES[i / 128], 3'h5, 2'h0, i[6:0]};
			if (w[15:12] == 4'h8) w[6:5] = 2'h0;
			wr(ADDR_TX_MODE, w);
			chk_cfg(exp_cfg(w));
		end
		chk_twist(4'h0);
		$display("framing test done");
	endtask
	task automatic t_twist();
		logic [15:0] w;
		for (int i = 0; i < 8; i++) begin
			w = {4'h1, 3'h6, 1'b0, i[2:0], 5'h15};
			wr(ADDR_TX_MODE, w);
			chk_cfg(exp_cfg(w));
			chk_twist(TW[i]);
		end
		@(posedge clk);
		tone <= 1'b1;
		wr(ADDR_TX_MODE, 16'h1C15);
		repeat (5) @(posedge clk);
		#1;
		chk_twist(4'h9);
		@(posedge clk);
		tone <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_twist(4'h4);
		$display("twist test done");
	endtask
	task automatic t_clears();
		wr(ADDR_TX_MODE, 16'hD0DF);
		chk_cfg(exp_cfg(16'hD0DF));
		wr(ADDR_GEN_RESET, 16'hFFFF);
		chk_cfg('0);
		wr(ADDR_TX_MODE, 16'hD0DF);
		wr(ADDR_GEN_CTRL, 16'h0080);
		chk_cfg('0);
		chk_bit(int_rst, 1'b1, "int reset");
		wr(ADDR_TX_MODE, 16'hD0DF);
		chk_cfg('0);
		wr(ADDR_GEN_CTRL, 16'h0000);
		chk_bit(int_rst, 1'b0, "int reset off");
		wr(ADDR_TX_MODE, 16'hA5F3);
		wr(8'hE2, 16'h0000);
		chk_cfg(exp_cfg(16'hA5F3));
		$display("clear test done");
	endtask
	task automatic t_irq();
		for (int b = 0; b < 6; b++) begin
			wr(ADDR_GEN_CTRL, 16'h0040 | (16'h0001 << b));
			for (int f = 0; f < 6; f++) begin
				@(posedge clk);
				flags <= 6'h01 << f;
				repeat (2) @(posedge clk);
				#1;
				chk_bit(irq, f == b, "irq bit");
				chk_bit(irq_oe, f == b, "irq oe");
				chk_bit(irq_out, 1'b0, "irq level");
			end
		end
		wr(ADDR_GEN_CTRL, 16'h003F);
		chk_bit(irq, 1'b1, "irq bit");
		chk_bit(irq_oe, 1'b0, "irq oe off");
		wr(ADDR_GEN_CTRL, 16'h0060);
		chk_bit(irq_oe, 1'b1, "irq oe on");
		wr(ADDR_GEN_RESET, 16'h0000);
		chk_bit(irq_oe, 1'b0, "irq oe reset");
		chk_bit(irq, 1'b0, "irq bit reset");
		$display("interrupt test done");
	endtask
	task automatic t_sys_reset();
		wr(ADDR_GEN_CTRL, 16'h0060);
		wr(ADDR_TX_MODE, 16'h1A15);
		chk_bit(irq_oe, 1'b1, "oe before reset");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk_cfg('0);
		chk_twist(4'h0);
		chk_bit(irq_oe, 1'b0, "oe after mid reset");
		chk_bit(irq, 1'b0, "irq after mid reset");
		chk_bit(int_rst, 1'b0, "int reset after mid reset");
		wr(ADDR_TX_MODE, 16'h1A15);
		chk_cfg(exp_cfg(16'h1A15));
		chk_twist(4'h4);
		$display("system reset test done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		#50us;
		fail("timeout");
		complete_run();
	end
	initial begin
		rst   = 1'b1;
		tone  = 1'b0;
		flags = 6'h00;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk_cfg('0);
		chk_bit(irq_oe, 1'b0, "oe after reset");
		t_modes();
		t_framing();
		t_twist();
		t_clears();
		t_irq();
		t_sys_reset();
		complete_run();
	end
endmodule
`default_nettype wire
